/* File: rtl/ttc_pkg.sv */
// Package with register map, field layout, reset values and types of the transfer control regs
package ttc_pkg;

  // Register byte addresses
  localparam logic [15:0] ADDR_LENGTH   = 16'h1000;
  localparam logic [15:0] ADDR_COMMAND  = 16'h1004;

  // Valid length range
  localparam logic [31:0] LENGTH_MIN    = 32'h00000001;
  localparam logic [31:0] LENGTH_MAX    = 32'h0FFFFFFF;

  // Command write field positions
  localparam int          CMD_START_N   = 0;
  localparam int          CMD_VERIFY    = 1;

  // Command read field positions
  localparam int          STAT_BUSY     = 0;
  localparam int          STAT_ERROR    = 1;

  // Reset values
  localparam logic [31:0] LENGTH_RST    = 32'h00000000;
  localparam logic [31:0] COUNT_RST     = 32'h00000000;
  localparam logic        VERIFY_RST    = 1'b0;
  localparam logic        ERROR_RST     = 1'b0;
  localparam logic [31:0] RDATA_RST     = 32'h00000000;

  // Generator states
  typedef enum logic [0:0] {
    TTC_IDLE = 1'b0,
    TTC_SEND = 1'b1
  } ttc_state_t;

  // Status word returned by a command read
  typedef struct packed {
    logic [29:0] zero;
    logic        error;
    logic        busy;
  } ttc_status_t;

  // APB answer carried together
  typedef struct packed {
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } ttc_apb_rsp_t;

endpackage : ttc_pkg

/* File: rtl/ttc_regs.sv */
// Transfer control register block with APB slave, word counter and generator control
`timescale 1ns/1ps

module ttc_regs #(
  parameter int ADDR_W = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Transmit side of the pattern generator
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  // Checker side
  output logic                   verify_enable,
  input  wire logic              verify_mismatch
);

  // Register and state flops with their next values
  ttc_pkg::ttc_state_t   state;
  ttc_pkg::ttc_state_t   next_state;
  logic [31:0]           total_length;
  logic [31:0]           next_total_length;
  logic [31:0]           sent_count;
  logic [31:0]           next_sent_count;
  logic                  verify_on;
  logic                  next_verify_on;
  logic                  error_flag;
  logic                  next_error_flag;
  ttc_pkg::ttc_apb_rsp_t rsp;
  ttc_pkg::ttc_apb_rsp_t next_rsp;

  // Decoded bus and word handshake events, counter sum and status word
  logic                  setup_phase;
  logic                  access_done;
  logic                  hit_length;
  logic                  hit_command;
  logic                  wr_length;
  logic                  wr_command;
  logic                  start_req;
  logic                  word_sent;
  logic                  last_word;
  logic [31:0]           count_plus;
  ttc_pkg::ttc_status_t  status;

  // Address decode on the full byte address
  always_comb begin
    hit_length  = (paddr == ADDR_W'(ttc_pkg::ADDR_LENGTH));
    hit_command = (paddr == ADDR_W'(ttc_pkg::ADDR_COMMAND));
  end

  // Bus phases; a write takes effect only at the completing edge
  always_comb begin
    setup_phase = psel & ~penable;
    access_done = psel & penable & rsp.ready;
    wr_length   = access_done & pwrite & hit_length;
    wr_command  = access_done & pwrite & hit_command;
  end

  // Start request: command write with start bit low
  always_comb begin
    start_req = wr_command & ~pwdata[ttc_pkg::CMD_START_N];
  end

  // Word handshake and end-of-transfer detect
  always_comb begin
    word_sent  = (state == ttc_pkg::TTC_SEND) & tx_ready;
    count_plus = sent_count + 32'h00000001;
    last_word  = word_sent & (count_plus == total_length);
  end

  // Status word seen by a command read
  always_comb begin
    status       = '0;
    status.busy  = (state == ttc_pkg::TTC_SEND);
    status.error = error_flag;
  end

  // Next value of the programmed total length
  always_comb begin
    next_total_length = total_length;
    if (wr_length) begin
      next_total_length = pwdata;
    end
  end

  // Next value of the verify enable
  always_comb begin
    next_verify_on = verify_on;
    if (wr_command) begin
      next_verify_on = pwdata[ttc_pkg::CMD_VERIFY];
    end
  end

  // Generator state machine
  always_comb begin
    next_state = state;
    case (state)
      ttc_pkg::TTC_IDLE: begin
        // Zero length would never finish, so it does not start
        if (start_req && (next_total_length >= ttc_pkg::LENGTH_MIN)) begin
          next_state = ttc_pkg::TTC_SEND;
        end
      end
      ttc_pkg::TTC_SEND: begin
        if (last_word) begin
          next_state = ttc_pkg::TTC_IDLE;
        end
      end
      default: begin
        next_state = ttc_pkg::TTC_IDLE;
      end
    endcase
  end

  // Sent-word counter; a command write overrides an increment
  always_comb begin
    next_sent_count = sent_count;
    if (wr_command) begin
      next_sent_count = ttc_pkg::COUNT_RST;
    end else if (word_sent) begin
      next_sent_count = count_plus;
    end
  end

  // Mismatch flag; a new command clears it, a mismatch in that cycle wins
  always_comb begin
    next_error_flag = error_flag;
    if (wr_command) begin
      next_error_flag = 1'b0;
    end
    if (verify_on && verify_mismatch) begin
      next_error_flag = 1'b1;
    end
  end

  // APB answer: ready in the access cycle, data captured at setup
  always_comb begin
    next_rsp        = rsp;
    next_rsp.ready  = setup_phase;
    if (setup_phase) begin
      next_rsp.slverr = ~(hit_length | hit_command);
      next_rsp.rdata  = ttc_pkg::RDATA_RST;
      if (!pwrite && hit_length) begin
        next_rsp.rdata = next_sent_count;
      end else if (!pwrite && hit_command) begin
        next_rsp.rdata = 32'(status);
      end
    end else if (access_done) begin
      next_rsp.slverr = 1'b0;
      next_rsp.rdata  = ttc_pkg::RDATA_RST;
    end
  end

  // Register stage; clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= ttc_pkg::TTC_IDLE;
      total_length <= ttc_pkg::LENGTH_RST;
      sent_count   <= ttc_pkg::COUNT_RST;
      verify_on    <= ttc_pkg::VERIFY_RST;
      error_flag   <= ttc_pkg::ERROR_RST;
      rsp          <= '0;
    end else if (clk_en) begin
      state        <= next_state;
      total_length <= next_total_length;
      sent_count   <= next_sent_count;
      verify_on    <= next_verify_on;
      error_flag   <= next_error_flag;
      rsp          <= next_rsp;
    end
  end

  // Outputs come straight from flops
  always_comb begin
    prdata        = rsp.rdata;
    pready        = rsp.ready;
    pslverr       = rsp.slverr;
    tx_valid      = (state == ttc_pkg::TTC_SEND);
    verify_enable = verify_on;
  end

endmodule : ttc_regs

/* File: verif/ttc_regs_checker.sv */
// Assertion checker for the transfer control register block
`timescale 1ns/1ps
module ttc_regs_checker #(parameter int ADDR_W = 16) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              clk_en,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic              verify_enable,
  input wire logic              verify_mismatch
);
  // Decoded accesses
  wire acc  = psel & penable & pready & clk_en;
  wire is_c = paddr == ttc_pkg::ADDR_COMMAND;
  wire is_l = paddr == ttc_pkg::ADDR_LENGTH;
  wire cw   = acc & pwrite & is_c;
  logic [31:0] len_q;
  logic [31:0] cnt_q;
  // Shadow of programmed total and sent words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_q <= 32'h0;
      cnt_q <= 32'h0;
    end else if (clk_en) begin
      if (acc & pwrite & is_l) len_q <= pwdata;
      if (cw) cnt_q <= 32'h0;
      else if (tx_valid & tx_ready) cnt_q <= cnt_q + 32'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RDY: assert property (psel & ~penable & clk_en |=> pready)
    else $error("pready missing after setup");
  AST_ERR: assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_START: assert property (cw & ~pwdata[0] & (len_q != 0) |=> tx_valid)
    else $error("transfer did not start");
  AST_NOSTART: assert property (cw & pwdata[0] & ~tx_valid |=> ~tx_valid)
    else $error("transfer started with bit0 high");
  AST_VERIFY: assert property (cw |=> verify_enable == $past(pwdata[1]))
    else $error("verify enable not taken");
  AST_BUSY_RD: assert property (acc & ~pwrite & is_c |->
    prdata[0] == $past(tx_valid)) else $error("busy read wrong");
  AST_COUNT_RD: assert property (acc & ~pwrite & is_l |-> prdata == cnt_q)
    else $error("count read wrong");
  AST_STOP: assert property (tx_valid |-> cnt_q != len_q)
    else $error("sending past total");
endmodule : ttc_regs_checker

bind ttc_regs ttc_regs_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .clk_en, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_valid, .tx_ready,
  .verify_enable, .verify_mismatch);

/* File: verif/ttc_regs_bench.sv */
// Directed register tests for the transfer control block
`timescale 1ns/1ps
module ttc_regs_bench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        tx_ready = 1'b0, mism = 1'b0, pready, pslverr, tx_valid, verify_enable, rd_err;
  logic        clk_en = 1'b1;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  int          errors = 0, check_count = 0, n;
  // Clock generator
  always #20 pclk = ~pclk;
  ttc_regs u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tx_valid, .tx_ready, .verify_enable, .verify_mismatch(mism));
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      $display("Error %s expected %h seen %h", s, x, g);
      errors++;
    end
  endtask : chk
  // Bounded wait at rising edges
  task automatic wait_for(input logic [31:0] lim, input logic v);
    n = 0;
    while (!v && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_for
  // One APB transfer, result in rd_data and rd_err
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      errors++;
      finish_test();
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Mismatch pulse of one cycle
  task automatic pulse();
    mism <= 1'b1;
    @(posedge pclk);
    mism <= 1'b0;
  endtask : pulse
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ttc_pkg::ADDR_COMMAND, 32'h0);
    chk("status", 32'h0, rd_data);
    $display("Test reset done");
    apb(1'b1, ttc_pkg::ADDR_LENGTH, 32'h3);
    apb(1'b1, ttc_pkg::ADDR_COMMAND, 32'h2);
    chk("verify_enable", 32'h1, {31'h0, verify_enable});
    apb(1'b0, ttc_pkg::ADDR_COMMAND, 32'h0);
    chk("busy", 32'h1, rd_data);
    apb(1'b0, ttc_pkg::ADDR_LENGTH, 32'h0);
    chk("stalled count", 32'h0, rd_data);
    tx_ready <= 1'b1;
    n = 0;
    while (tx_valid !== 1'b0 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) begin
      errors++;
      finish_test();
    end
    chk("tx_valid", 32'h0, {31'h0, tx_valid});
    apb(1'b0, ttc_pkg::ADDR_LENGTH, 32'h0);
    chk("sent count", 32'h3, rd_data);
    $display("Test transfer done");
    pulse();
    apb(1'b0, ttc_pkg::ADDR_COMMAND, 32'h0);
    chk("error", 32'h2, rd_data);
    apb(1'b1, ttc_pkg::ADDR_COMMAND, 32'h1);
    chk("verify_enable off", 32'h0, {31'h0, verify_enable});
    apb(1'b0, ttc_pkg::ADDR_LENGTH, 32'h0);
    chk("cleared count", 32'h0, rd_data);
    pulse();
    apb(1'b0, ttc_pkg::ADDR_COMMAND, 32'h0);
    chk("idle status", 32'h0, rd_data);
    // Clock enable low freezes a running transfer
    apb(1'b1, ttc_pkg::ADDR_LENGTH, 32'h2);
    apb(1'b1, ttc_pkg::ADDR_COMMAND, 32'h0);
    clk_en <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("frozen tx_valid", 32'h1, {31'h0, tx_valid});
    clk_en <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("thawed tx_valid", 32'h0, {31'h0, tx_valid});
    apb(1'b0, ttc_pkg::ADDR_LENGTH, 32'h0);
    chk("frozen count", 32'h2, rd_data);
    // Zero length is refused
    apb(1'b1, ttc_pkg::ADDR_LENGTH, 32'h0);
    apb(1'b1, ttc_pkg::ADDR_COMMAND, 32'h0);
    apb(1'b0, ttc_pkg::ADDR_COMMAND, 32'h0);
    chk("zero length idle", 32'h0, rd_data);
    apb(1'b0, 16'h2000, 32'h0);
    chk("pslverr", 32'h1, {31'h0, rd_err});
    $display("Test command done");
    finish_test();
  end
endmodule : ttc_regs_bench
